// File: inc/rxja_pkg.sv
// Shared constants and types of the receive output and jitter buffer block
`default_nettype none
package rxja_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_LATCH = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0C;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // ==========================================================
  // Control fields
  localparam int CTRL_INV = 0;
  localparam int CTRL_ROD = 1;
  localparam int CTRL_RPD = 2;
  localparam int CTRL_T2E = 3;
  localparam int CTRL_TRE = 4;
  localparam int CTRL_LOC = 5;
  localparam int CTRL_DEP = 7;
  // ==========================================================
  // Status and event bits
  localparam int ST_FAIL1 = 0;
  localparam int ST_FAIL2 = 1;
  localparam int ST_FULL = 2;
  localparam int ST_EMPTY = 3;
  localparam int N_EV = 4;
  localparam int EV_FULL = 0;
  localparam int EV_EMPTY = 1;
  localparam int EV_FAIL1 = 2;
  localparam int EV_FAIL2 = 3;
  localparam logic [3:0] EV_RST = 4'h0;
  // ==========================================================
  // Buffer location and hardware mode
  localparam logic [1:0] LOC_OFF = 2'h0;
  localparam logic [1:0] LOC_RX = 2'h1;
  localparam logic [1:0] LOC_TX = 2'h2;
  localparam logic [1:0] INTERFACE_SELECT_HW = 2'h0;
  // ==========================================================
  // Buffer geometry
  localparam int JB_MAX = 128;
  localparam int PTR_W = 7;
  localparam int CNT_W = 8;
  localparam logic [7:0] DEPTH_BASE = 8'h10;
  // ==========================================================
  // Retiming loop
  localparam int LOOP_DIV = 2058874;
  localparam int LOOP_W = 22;
  localparam longint PPM_ADJ = 6250;
  localparam longint PPM_DEN = 1000000;
  localparam logic [31:0] NCO_NOM = 32'h2000_0000;
  localparam logic [15:0] TRIM_RST = 16'h0000;
  localparam logic [15:0] TRIM_ONE = 16'h0001;
  typedef enum logic [1:0] {
    RXJA_ADJ_NONE = 2'b00,
    RXJA_ADJ_FAST = 2'b01,
    RXJA_ADJ_SLOW = 2'b10
  } rxja_adj_t;
endpackage
`default_nettype wire

// File: design/rxja_fifo.sv
// Bit buffer of the jitter attenuator with selectable depth
`default_nettype none
module rxja_fifo (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Configuration
  input wire logic [1:0] depth_sel_i,
  input wire logic flush_i,
  // Write side
  input wire logic wr_i,
  input wire logic wr_pos_i,
  input wire logic wr_neg_i,
  // Read side
  input wire logic rd_i,
  output logic rd_pos_o,
  output logic rd_neg_o,
  // Fill state
  output logic [rxja_pkg::CNT_W-1:0] fill_o,
  output logic [rxja_pkg::CNT_W-1:0] depth_o,
  output logic full_o,
  output logic empty_o,
  output logic overflow_o,
  output logic underflow_o
);
  localparam int CNT_W = rxja_pkg::CNT_W;
  localparam int PTR_W = rxja_pkg::PTR_W;

  typedef struct packed {
    logic [rxja_pkg::JB_MAX-1:0] mem_pos;
    logic [rxja_pkg::JB_MAX-1:0] mem_neg;
    logic [rxja_pkg::PTR_W-1:0] wr_ptr;
    logic [rxja_pkg::PTR_W-1:0] rd_ptr;
    logic [rxja_pkg::CNT_W-1:0] fill;
    logic ovf;
    logic udf;
  } rxja_fifo_state_t;

  rxja_fifo_state_t s;
  rxja_fifo_state_t next_s;
  logic [rxja_pkg::CNT_W-1:0] depth;
  logic [rxja_pkg::PTR_W-1:0] ptr_mask;
  logic wr_ok;
  logic rd_ok;

  // ==========================================================
  // Depth 16, 32, 64 or 128
  assign depth = rxja_pkg::DEPTH_BASE << depth_sel_i;
  assign ptr_mask = PTR_W'(depth - 1'b1);
  assign full_o = (s.fill == depth);
  assign empty_o = (s.fill == '0);
  // A read in the same cycle frees the slot that a write into a full buffer needs
  assign wr_ok = wr_i & (~full_o | rd_ok);
  assign rd_ok = rd_i & ~empty_o;

  always_comb begin
    next_s = s;
    next_s.ovf = wr_i & ~wr_ok;
    next_s.udf = rd_i & empty_o;
    if (wr_ok) begin
      next_s.mem_pos[s.wr_ptr] = wr_pos_i;
      next_s.mem_neg[s.wr_ptr] = wr_neg_i;
      next_s.wr_ptr = (s.wr_ptr + 1'b1) & ptr_mask;
    end
    if (rd_ok) begin
      next_s.rd_ptr = (s.rd_ptr + 1'b1) & ptr_mask;
    end
    next_s.fill = s.fill + CNT_W'(wr_ok) - CNT_W'(rd_ok);
    if (flush_i) begin
      next_s.wr_ptr = '0;
      next_s.rd_ptr = '0;
      next_s.fill = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rd_pos_o = s.mem_pos[s.rd_ptr];
  assign rd_neg_o = s.mem_neg[s.rd_ptr];
  assign fill_o = s.fill;
  assign depth_o = depth;
  assign overflow_o = s.ovf;
  assign underflow_o = s.udf;

  property p_fill_bound;
    @(posedge clk_i) disable iff (rst_i)
      $stable(depth_sel_i) |-> (s.fill <= depth);
  endproperty
  a_fill_bound: assert property (p_fill_bound)
    else $error("Buffer fill above selected depth");
endmodule
`default_nettype wire

// File: design/rxja_top.sv
// Receive output control, input failure report and jitter attenuator of one port
// ==========================================================
//
// Added by the designer: the register addresses and the Wishbone slave port.
`default_nettype none
module rxja_top #(
  parameter int LOOP_CYCLES = rxja_pkg::LOOP_DIV,
  parameter logic [31:0] NCO_INC = rxja_pkg::NCO_NOM
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Hardware mode pins
  input wire logic [2:0] interface_select_i,
  input wire logic recovered_clock_invert_i,
  input wire logic rx_power_down_i,
  input wire logic [1:0] jitter_buffer_location_i,
  input wire logic [1:0] jitter_buffer_depth_i,
  // Recovered receive side
  input wire logic rec_clk_i,
  input wire logic rec_pos_i,
  input wire logic rec_neg_i,
  // Line input monitors
  input wire logic open_positive_i,
  input wire logic open_negative_i,
  input wire logic short_supply_i,
  input wire logic short_ground_i,
  input wire logic activity_positive_i,
  input wire logic activity_negative_i,
  input wire logic high_impedance_i,
  // Transmit path through the buffer
  input wire logic tx_clk_i,
  input wire logic tx_pos_i,
  input wire logic tx_neg_i,
  output logic tx_clk_o,
  output logic tx_pos_o,
  output logic tx_neg_o,
  // Receive outputs to the framer
  output logic rx_clk_o,
  output logic rx_clk_oe_o,
  output logic rx_positive_pulse_out_o,
  output logic rx_negative_pulse_out_o,
  output logic rx_data_oe_o,
  // Line front end control
  output logic line_in_active_o,
  output logic internal_termination_enable_o,
  output logic type_two_detect_enable_o,
  // Interrupt
  output logic irq_o
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [rxja_pkg::N_EV-1:0] latch;
    logic [rxja_pkg::N_EV-1:0] mask;
    logic ack;
    logic [31:0] dat;
    logic rec_clk;
    logic tx_clk;
    logic [31:0] phase;
    logic [15:0] trim;
    logic [rxja_pkg::LOOP_W-1:0] loop_cnt;
    rxja_pkg::rxja_adj_t adj;
    logic [1:0] depth_q;
    logic [1:0] loc_q;
    logic fail1;
    logic fail2;
    logic full_q;
    logic empty_q;
    logic rx_clk;
    logic rx_pos;
    logic rx_neg;
    logic rx_oe;
    logic line_act;
    logic tx_clk_out;
    logic tx_pos;
    logic tx_neg;
  } rxja_top_state_t;

  localparam logic [rxja_pkg::LOOP_W-1:0] LOOP_LAST = rxja_pkg::LOOP_W'(LOOP_CYCLES - 1);

  rxja_top_state_t s;
  rxja_top_state_t next_s;
  logic hw_mode;
  logic inv;
  logic pd;
  logic [1:0] loc;
  logic [1:0] depth_sel;
  logic ja_rx;
  logic ja_tx;
  logic flush;
  logic fail_cond;
  logic rec_rise;
  logic rec_fall;
  logic tx_rise;
  logic tx_fall;
  logic [31:0] inc;
  logic [31:0] delta;
  logic [63:0] product;
  logic [31:0] phase_nx;
  logic nco_rise;
  logic nco_fall;
  logic rx_launch;
  logic fifo_wr;
  logic fifo_rd;
  logic fifo_pos;
  logic fifo_neg;
  logic [rxja_pkg::CNT_W-1:0] fill;
  logic [rxja_pkg::CNT_W-1:0] depth;
  logic full;
  logic empty;
  logic ovf;
  logic udf;
  logic [rxja_pkg::N_EV-1:0] events;
  logic [rxja_pkg::N_EV-1:0] clr;
  logic wb_req;
  logic wb_wr;

  // Byte-lane merge of a register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================================
  // Mode selection
  assign hw_mode = (interface_select_i[2:1] == rxja_pkg::INTERFACE_SELECT_HW);
  assign inv = hw_mode ? recovered_clock_invert_i : s.ctrl[rxja_pkg::CTRL_INV];
  assign pd = hw_mode ? rx_power_down_i : s.ctrl[rxja_pkg::CTRL_RPD];
  assign loc = hw_mode ? jitter_buffer_location_i : s.ctrl[rxja_pkg::CTRL_LOC +: 2];
  assign depth_sel = hw_mode ? jitter_buffer_depth_i : s.ctrl[rxja_pkg::CTRL_DEP +: 2];
  assign ja_rx = (loc == rxja_pkg::LOC_RX);
  assign ja_tx = (loc == rxja_pkg::LOC_TX);
  assign flush = ~(ja_rx | ja_tx) | (loc != s.loc_q) | (depth_sel != s.depth_q);
  assign fail_cond = open_positive_i | open_negative_i | short_supply_i | short_ground_i;

  // ==========================================================
  // Edges of the sampled clocks
  assign rec_rise = rec_clk_i & ~s.rec_clk;
  assign rec_fall = ~rec_clk_i & s.rec_clk;
  assign tx_rise = tx_clk_i & ~s.tx_clk;
  assign tx_fall = ~tx_clk_i & s.tx_clk;

  // ==========================================================
  // Read clock synthesis
  assign product = 64'(inc) * 64'(rxja_pkg::PPM_ADJ);
  assign delta = 32'(product / 64'(rxja_pkg::PPM_DEN));
  always_comb begin
    inc = NCO_INC + {{16{s.trim[15]}}, s.trim};
    if (s.adj == rxja_pkg::RXJA_ADJ_FAST) begin
      inc = NCO_INC + {{16{s.trim[15]}}, s.trim} + delta;
    end else if (s.adj == rxja_pkg::RXJA_ADJ_SLOW) begin
      inc = NCO_INC + {{16{s.trim[15]}}, s.trim} - delta;
    end
  end
  assign phase_nx = s.phase + inc;
  assign nco_rise = phase_nx[31] & ~s.phase[31];
  assign nco_fall = ~phase_nx[31] & s.phase[31];

  // ==========================================================
  // Buffer wiring
  assign rx_launch = ja_rx ? (inv ? nco_rise : nco_fall) : (inv ? rec_rise : rec_fall);
  assign fifo_wr = ja_rx ? rec_rise : (ja_tx & tx_rise);
  assign fifo_rd = ja_rx ? rx_launch : (ja_tx & nco_fall);

  rxja_fifo u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .depth_sel_i(depth_sel),
    .flush_i(flush),
    .wr_i(fifo_wr),
    .wr_pos_i(ja_rx ? rec_pos_i : tx_pos_i),
    .wr_neg_i(ja_rx ? rec_neg_i : tx_neg_i),
    .rd_i(fifo_rd),
    .rd_pos_o(fifo_pos),
    .rd_neg_o(fifo_neg),
    .fill_o(fill),
    .depth_o(depth),
    .full_o(full),
    .empty_o(empty),
    .overflow_o(ovf),
    .underflow_o(udf)
  );

  // ==========================================================
  // Events
  always_comb begin
    events = '0;
    if (~hw_mode) begin
      events[rxja_pkg::EV_FULL] = (full & ~s.full_q) | ovf | udf;
      events[rxja_pkg::EV_EMPTY] = (empty & ~s.empty_q & ~flush) | ovf | udf;
    end
    events[rxja_pkg::EV_FAIL1] = fail_cond & ~s.fail1;
    events[rxja_pkg::EV_FAIL2] = s.ctrl[rxja_pkg::CTRL_T2E] & high_impedance_i & ~s.fail2;
  end

  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_wr = wb_req & wb_we_i & s.ack;
  assign clr = (wb_wr && wb_adr_i == rxja_pkg::ADDR_LATCH && wb_sel_i[0]) ?
               wb_dat_i[rxja_pkg::N_EV-1:0] : '0;

  // ==========================================================
  // Next state
  always_comb begin
    next_s = s;
    next_s.rec_clk = rec_clk_i;
    next_s.tx_clk = tx_clk_i;
    next_s.loc_q = loc;
    next_s.depth_q = depth_sel;
    next_s.full_q = full;
    next_s.empty_q = empty;
    // Bus slave: ack one cycle after the request, dropped the next
    next_s.ack = wb_req & ~s.ack;
    next_s.dat = rxja_pkg::WORD_ZERO;
    if (wb_req & ~s.ack & ~wb_we_i) begin
      unique case (wb_adr_i)
        rxja_pkg::ADDR_CTRL: next_s.dat = s.ctrl;
        rxja_pkg::ADDR_STAT: begin
          next_s.dat[rxja_pkg::ST_FAIL1] = s.fail1;
          next_s.dat[rxja_pkg::ST_FAIL2] = s.fail2;
          next_s.dat[rxja_pkg::ST_FULL] = full;
          next_s.dat[rxja_pkg::ST_EMPTY] = empty;
        end
        rxja_pkg::ADDR_LATCH: next_s.dat[rxja_pkg::N_EV-1:0] = s.latch;
        rxja_pkg::ADDR_MASK: next_s.dat[rxja_pkg::N_EV-1:0] = s.mask;
        default: next_s.dat = rxja_pkg::WORD_ZERO;
      endcase
    end
    if (wb_wr && wb_adr_i == rxja_pkg::ADDR_CTRL) begin
      next_s.ctrl = merge(s.ctrl, wb_dat_i, wb_sel_i);
    end
    if (wb_wr && wb_adr_i == rxja_pkg::ADDR_MASK && wb_sel_i[0]) begin
      next_s.mask = wb_dat_i[rxja_pkg::N_EV-1:0];
    end
    // Set wins over a write-one clear
    next_s.latch = (s.latch & ~clr) | events;
    // Line input failures
    if (fail_cond) begin
      next_s.fail1 = 1'b1;
    end else if (activity_positive_i & activity_negative_i) begin
      next_s.fail1 = 1'b0;
    end
    next_s.fail2 = s.ctrl[rxja_pkg::CTRL_T2E] & high_impedance_i;
    // Read clock and its slow centring loop
    next_s.phase = (ja_rx | ja_tx) ? phase_nx : s.phase;
    if (s.loop_cnt == LOOP_LAST) begin
      next_s.loop_cnt = '0;
      // Frozen while adjusting so that jitter passes through
      if (s.adj == rxja_pkg::RXJA_ADJ_NONE) begin
        if (fill > (depth >> 1)) begin
          next_s.trim = s.trim + rxja_pkg::TRIM_ONE;
        end else if (fill < (depth >> 1)) begin
          next_s.trim = s.trim - rxja_pkg::TRIM_ONE;
        end
      end
    end else begin
      next_s.loop_cnt = s.loop_cnt + 1'b1;
    end
    if (flush) begin
      next_s.trim = rxja_pkg::TRIM_RST;
    end
    // Frequency adjustment
    unique case (s.adj)
      rxja_pkg::RXJA_ADJ_NONE: next_s.adj = rxja_pkg::RXJA_ADJ_NONE;
      rxja_pkg::RXJA_ADJ_FAST:
        next_s.adj = (fill <= (depth >> 1)) ? rxja_pkg::RXJA_ADJ_NONE : rxja_pkg::RXJA_ADJ_FAST;
      rxja_pkg::RXJA_ADJ_SLOW:
        next_s.adj = (fill >= (depth >> 1)) ? rxja_pkg::RXJA_ADJ_NONE : rxja_pkg::RXJA_ADJ_SLOW;
      default: next_s.adj = rxja_pkg::RXJA_ADJ_NONE;
    endcase
    if (full) begin
      next_s.adj = rxja_pkg::RXJA_ADJ_FAST;
    end else if (empty) begin
      next_s.adj = rxja_pkg::RXJA_ADJ_SLOW;
    end
    if (flush) begin
      next_s.adj = rxja_pkg::RXJA_ADJ_NONE;
    end
    // Receive outputs
    next_s.rx_clk = ja_rx ? phase_nx[31] : rec_clk_i;
    if (rx_launch) begin
      next_s.rx_pos = ja_rx ? fifo_pos : rec_pos_i;
      next_s.rx_neg = ja_rx ? fifo_neg : rec_neg_i;
    end
    next_s.rx_oe = ~s.ctrl[rxja_pkg::CTRL_ROD] & ~pd;
    next_s.line_act = ~pd;
    // Transmit outputs
    next_s.tx_clk_out = ja_tx ? phase_nx[31] : tx_clk_i;
    if (ja_tx ? nco_fall : tx_fall) begin
      next_s.tx_pos = ja_tx ? fifo_pos : tx_pos_i;
      next_s.tx_neg = ja_tx ? fifo_neg : tx_neg_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.ctrl <= rxja_pkg::CTRL_RST;
      s.mask <= rxja_pkg::EV_RST;
      s.trim <= rxja_pkg::TRIM_RST;
      s.adj <= rxja_pkg::RXJA_ADJ_NONE;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.dat;
  assign rx_clk_o = s.rx_clk;
  assign rx_clk_oe_o = s.rx_oe;
  assign rx_data_oe_o = s.rx_oe;
  assign rx_positive_pulse_out_o = s.rx_pos;
  assign rx_negative_pulse_out_o = s.rx_neg;
  assign line_in_active_o = s.line_act;
  assign internal_termination_enable_o = s.ctrl[rxja_pkg::CTRL_TRE];
  assign type_two_detect_enable_o = s.ctrl[rxja_pkg::CTRL_T2E];
  assign tx_clk_o = s.tx_clk_out;
  assign tx_pos_o = s.tx_pos;
  assign tx_neg_o = s.tx_neg;
  assign irq_o = |(s.latch & s.mask);

  // ==========================================================
  // Assertions
  property p_launch_edge;
    @(posedge clk_i) disable iff (rst_i)
      $changed(s.rx_pos) |-> $past(rx_launch);
  endproperty
  a_launch_edge: assert property (p_launch_edge)
    else $error("Receive data changed away from its launch edge");

  property p_disable;
    @(posedge clk_i) disable iff (rst_i)
      s.ctrl[rxja_pkg::CTRL_ROD] |=> !rx_clk_oe_o && !rx_data_oe_o;
  endproperty
  a_disable: assert property (p_disable)
    else $error("Receive outputs driven while disabled");

  property p_power_down;
    @(posedge clk_i) disable iff (rst_i)
      pd |=> !line_in_active_o && !rx_data_oe_o && !rx_clk_oe_o;
  endproperty
  a_power_down: assert property (p_power_down)
    else $error("Pins active during power-down");

  property p_fail1_set;
    @(posedge clk_i) disable iff (rst_i)
      fail_cond && !s.fail1 |=> s.fail1 && s.latch[rxja_pkg::EV_FAIL1];
  endproperty
  a_fail1_set: assert property (p_fail1_set)
    else $error("Type one failure not reported");

  property p_fail1_hold;
    @(posedge clk_i) disable iff (rst_i)
      s.fail1 && !(activity_positive_i && activity_negative_i) |=> s.fail1;
  endproperty
  a_fail1_hold: assert property (p_fail1_hold)
    else $error("Type one failure cleared without activity");

  property p_fail2;
    @(posedge clk_i) disable iff (rst_i)
      s.ctrl[rxja_pkg::CTRL_T2E] && high_impedance_i |=> s.fail2;
  endproperty
  a_fail2: assert property (p_fail2)
    else $error("Type two failure not reported");

  property p_speed_up;
    @(posedge clk_i) disable iff (rst_i)
      full && !flush |=> s.adj == rxja_pkg::RXJA_ADJ_FAST;
  endproperty
  a_speed_up: assert property (p_speed_up)
    else $error("Read clock not raised on full buffer");

  property p_overflow;
    @(posedge clk_i) disable iff (rst_i)
      (ovf || udf) && !hw_mode |=> s.latch[rxja_pkg::EV_FULL] && s.latch[rxja_pkg::EV_EMPTY];
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("Data error not flagged on both latched bits");

  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
      events[rxja_pkg::EV_FULL] && next_s.mask[rxja_pkg::EV_FULL] |=> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Enabled full event gave no interrupt");

  property p_latch_hold;
    @(posedge clk_i) disable iff (rst_i)
      s.latch[rxja_pkg::EV_EMPTY] && !clr[rxja_pkg::EV_EMPTY] |=> s.latch[rxja_pkg::EV_EMPTY];
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("Latched empty bit lost without a clear");
endmodule
`default_nettype wire

// File: sim/rxja_framer.sv
// Downstream framer model watching receive clock and data
`default_nettype none
module rxja_framer (
  // Clock and expected launch edge
  input wire logic clk_i,
  input wire logic inv_i,
  // Receive lines
  input wire logic rx_clk_i,
  input wire logic oe_i,
  input wire logic pos_i,
  input wire logic neg_i,
  // Counts
  output int bad_o,
  output int chg_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] last = 2'h0;
  logic was = 1'b0;
  logic [1:0] seen;
  int bad = 0;
  int chg = 0;
  assign bad_o = bad;
  assign chg_o = chg;
  // Released lines float away from the last value
  assign seen = oe_i ? {pos_i, neg_i} : ~last;
  always @(negedge clk_i) begin
    if (oe_i && was && seen !== last) begin
      chg <= chg + 1;
      if (rx_clk_i !== inv_i) bad <= bad + 1;
    end
    last <= seen;
    was <= oe_i;
  end
endmodule
`default_nettype wire

// File: sim/rxja_top_tb.sv
// Self-checking bench of the receive output and jitter buffer block
`default_nettype none
module rxja_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, run = 1'b0, inv = 1'b0;
  logic rc = 1'b0, rp = 1'b0, rn = 1'b0, hinv = 1'b0, hpd = 1'b0, himp = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, q, rx_binary_data_out;
  logic [2:0] ifs = 3'h2;
  logic [1:0] hloc = 2'h0, hdep = 2'h0, act = 2'h0;
  logic [3:0] flt = 4'h0;
  logic ack, rclk, coe, doe, rx_positive_pulse_out, rx_negative_pulse_out, lia, ite, tde, irq, tclk, tpos, tneg;
  int fails = 0, comparisons = 0, half = 4, ph = 0, bad, chg, c0, c1;
  int tbad, tchg, c2, c3;
  always #20 clk_i = ~clk_i;
  rxja_top #(.LOOP_CYCLES(64)) u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rx_binary_data_out),
    .wb_ack_o(ack), .interface_select_i(ifs), .recovered_clock_invert_i(hinv),
    .rx_power_down_i(hpd), .jitter_buffer_location_i(hloc), .jitter_buffer_depth_i(hdep),
    .rec_clk_i(rc), .rec_pos_i(rp), .rec_neg_i(rn), .open_positive_i(flt[0]),
    .open_negative_i(flt[1]), .short_supply_i(flt[2]), .short_ground_i(flt[3]),
    .activity_positive_i(act[0]), .activity_negative_i(act[1]), .high_impedance_i(himp),
    .tx_clk_i(rc), .tx_pos_i(rp), .tx_neg_i(rn), .tx_clk_o(tclk), .tx_pos_o(tpos),
    .tx_neg_o(tneg), .rx_clk_o(rclk), .rx_clk_oe_o(coe), .rx_positive_pulse_out_o(rx_positive_pulse_out),
    .rx_negative_pulse_out_o(rx_negative_pulse_out), .rx_data_oe_o(doe), .line_in_active_o(lia),
    .internal_termination_enable_o(ite), .type_two_detect_enable_o(tde), .irq_o(irq));
  rxja_framer u_frm (.clk_i, .inv_i(inv), .rx_clk_i(rclk), .oe_i(doe), .pos_i(rx_positive_pulse_out),
    .neg_i(rx_negative_pulse_out), .bad_o(bad), .chg_o(chg));
  // Transmit side always changes data while its clock is low
  rxja_framer u_tfr (.clk_i, .inv_i(1'b0), .rx_clk_i(tclk), .oe_i(1'b1), .pos_i(tpos),
    .neg_i(tneg), .bad_o(tbad), .chg_o(tchg));
  // ==========================================================
  // Recovered line source
  always @(posedge clk_i) begin
    if (run) begin
      ph <= (ph >= half - 1) ? 0 : ph + 1;
      if (ph >= half - 1) begin
        rc <= ~rc;
        if (rc) {rp, rn} <= 2'($urandom_range(2, 0));
      end
    end
  end
  // ==========================================================
  // Bus and compare tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    we <= w;
    wdat <= d;
    cyc <= 1'b1;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    q = rx_binary_data_out;
    if (n == 20) fails++;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(q & m, e);
  endtask
  task automatic pins(input logic [4:0] e);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk(32'({ite, tde, coe, doe, lia}), 32'(e));
    @(posedge clk_i);
  endtask
  task automatic close_out;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    close_out;
  end
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'habd2));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h00, 32'h1ff, 32'h0);
    rd(8'h08, 32'hf, 32'h0);
    rd(8'h10, 32'hffff_ffff, 32'h0);
    for (int k = 0; k < 32; k++) begin
      if (k[3] && k[4]) continue;
      bus(8'h00, 1'b1, 32'(k));
      rd(8'h00, 32'h1ff, 32'(k));
      pins({k[4], k[3], ~(k[1] | k[2]), ~(k[1] | k[2]), ~k[2]});
    end
    bus(8'h00, 1'b1, 32'h0);
    ifs <= 3'h1;
    hpd <= 1'b1;
    pins(5'h00);
    ifs <= 3'h2;
    pins(5'h07);
    hpd <= 1'b0;
    bus(8'h0c, 1'b1, 32'h4);
    for (int k = 0; k < 4; k++) begin
      flt <= 4'h1 << k;
      act <= 2'h0;
      repeat (3) @(posedge clk_i);
      flt <= 4'h0;
      act <= 2'h1;
      rd(8'h04, 32'h1, 32'h1);
      act <= 2'h3;
      repeat (3) @(posedge clk_i);
      rd(8'h04, 32'h1, 32'h0);
    end
    rd(8'h08, 32'hf, 32'h4);
    chk(32'(irq), 32'h1);
    bus(8'h08, 1'b1, 32'h4);
    rd(8'h08, 32'hf, 32'h0);
    chk(32'(irq), 32'h0);
    bus(8'h00, 1'b1, 32'h8);
    himp <= 1'b1;
    @(posedge clk_i);
    rd(8'h04, 32'h2, 32'h2);
    bus(8'h00, 1'b1, 32'h0);
    rd(8'h04, 32'h2, 32'h0);
    himp <= 1'b0;
    $display("done: config and failures");
    for (int m = 0; m < 4; m++) begin
      if (m < 3) bus(8'h00, 1'b1, (m == 2) ? 32'h40 : 32'h20 | 32'(m));
      else begin
        ifs <= 3'h0;
        hinv <= 1'b1;
        hloc <= 2'h1;
        hdep <= 2'h3;
      end
      inv <= (m == 1 || m == 3);
      run <= 1'b1;
      repeat (50) @(posedge clk_i);
      c0 = bad;
      c1 = chg;
      c2 = tbad;
      c3 = tchg;
      repeat (500) @(posedge clk_i);
      chk(32'(bad - c0), 32'h0);
      chk(32'(chg - c1 > 10), 32'h1);
      chk(32'(tbad - c2), 32'h0);
      chk(32'(tchg - c3 > 10), 32'h1);
    end
    ifs <= 3'h2;
    hloc <= 2'h0;
    bus(8'h0c, 1'b1, 32'h3);
    half <= 1;
    for (int d = 0; d < 4; d++) begin
      run <= 1'b0;
      bus(8'h00, 1'b1, 32'h20 | 32'(d << 7));
      bus(8'h08, 1'b1, 32'h3);
      run <= 1'b1;
      repeat (8 * (16 << d) / 5) @(posedge clk_i);
      rd(8'h04, 32'h4, 32'h0);
      repeat (5 * (16 << d)) @(posedge clk_i);
      rd(8'h08, 32'h3, 32'h3);
      chk(32'(irq), 32'h1);
    end
    run <= 1'b0;
    $display("done: stream");
    close_out;
  end
endmodule
`default_nettype wire
